// file: hdl/bpg_cfg.svh
// register offsets, field positions, reset values and timing counts
`ifndef BPG_CFG_SVH
`define BPG_CFG_SVH
`define BPG_ADDR_OV          8'h14
`define BPG_ADDR_OC          8'h15
`define BPG_ADDR_SOC0        8'h16
`define BPG_OV_THR_HI        7
`define BPG_OV_THR_LO        3
`define BPG_OV_HYS_HI        2
`define BPG_OV_HYS_LO        1
`define BPG_OV_DGT_BIT       0
`define BPG_OC_THR_HI        7
`define BPG_OC_THR_LO        5
`define BPG_OC_DGT_HI        4
`define BPG_OC_DGT_LO        3
`define BPG_OV_HYS_RST       2'h0
`define BPG_OV_DGT_RST       1'h0
`define BPG_OC_DGT_RST       2'h1
`define BPG_SOC0_RST         8'h7D
`define BPG_OV_CODE_MAX      5'h18
`define BPG_OV_MV_BASE       16'd3550
`define BPG_OV_MV_STEP       16'd50
`define BPG_HYS_PCT_0        4'h2
`define BPG_HYS_PCT_1        4'h4
`define BPG_HYS_PCT_2        4'h6
`define BPG_HYS_PCT_3        4'h8
`define BPG_PCT_DIV          32'h64
`define BPG_SOC0_MV_BASE     16'h09C4
`define BPG_SOC0_MV_STEP     16'h0008
`define BPG_CLK_HZ           20000000
`define BPG_MS_CYCLES        (`BPG_CLK_HZ / 1000)
`define BPG_MS_W             15
`define BPG_MS_CNT_W         10
`define BPG_MS_PER_HALF_S    10'd500
`define BPG_MS_PER_S         10'd1000
`define BPG_MS_5             10'd5
`define BPG_MS_10            10'd10
`define BPG_MS_20            10'd20
`define BPG_MS_40            10'd40
`endif

// file: hdl/bpg_deglitch.sv
// qualification timer: fault after condition persists, release on clear
`default_nettype none
`include "bpg_cfg.svh"
module bpg_deglitch
    import bpg_pkg::*;
(
    input  wire logic                     clock_i,   // system clock
    input  wire logic                     reset_i,   // async reset, high
    input  wire logic                     ms_tick_i, // one-cycle 1 ms pulse
    input  wire logic                     trip_i,    // condition present
    input  wire logic                     clear_i,   // condition released
    input  wire logic [`BPG_MS_CNT_W-1:0] limit_i,   // qualify time in ms
    output var  logic                     fault_o    // qualified fault
);
    bpg_state_e                 state_q;
    logic [`BPG_MS_CNT_W-1:0]   cnt_q;

    // state machine with ms counter
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= BPG_OK;
            cnt_q   <= '0;
            fault_o <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                BPG_OK:
                begin
                    cnt_q <= '0;
                    if (trip_i)
                        state_q <= BPG_QUAL;
                end
                BPG_QUAL:
                begin
                    if (!trip_i)
                        state_q <= BPG_OK;
                    else if (ms_tick_i)
                    begin
                        if (cnt_q + 1'b1 >= limit_i)
                        begin
                            state_q <= BPG_FAULT;
                            fault_o <= 1'b1;
                        end
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                BPG_FAULT:
                begin
                    if (clear_i)
                    begin
                        state_q <= BPG_OK;
                        fault_o <= 1'b0;
                    end
                end
                default:
                    state_q <= BPG_OK;
            endcase
        end
    end
endmodule
`default_nettype wire

// file: hdl/bpg_pkg.sv
// types shared by the protection configuration bank
`default_nettype none
package bpg_pkg;
    typedef enum logic [1:0] {BPG_OK, BPG_QUAL, BPG_FAULT} bpg_state_e;
endpackage
`default_nettype wire

// file: hdl/bpg_regs.sv
// battery protection and gauge configuration register slice
// How it works
// - ov codes 10100-11000 4.55-4.75V, above 4.80V
// - ov threshold bits 7:3, 3.55V plus 50mV steps
// - hysteresis bits 2:1, reset 00, 2-8 percent
// - bit 0 deglitch, 0 half second, 1 second
// - oc threshold bits 7:5, 25 to 400 mA
// - oc deglitch bits 4:3, reset 01, 5-40ms
// - zero-percent breakpoint full eight bit value
// - breakpoint resets to 7D, 3.5 V
`default_nettype none
`include "bpg_cfg.svh"
module bpg_regs
    import bpg_pkg::*;
#(
    parameter logic [4:0] OV_THR_RST = 5'h0D, // factory trim value
    parameter logic [2:0] OC_THR_RST = 3'h3   // factory trim value
)
(
    input  wire logic        clock_i,       // 20 MHz system clock
    input  wire logic        reset_i,       // async reset, high
    input  wire logic [7:0]  reg_addr_i,    // register address
    input  wire logic        reg_wr_i,      // write strobe
    input  wire logic [7:0]  reg_wdata_i,   // write data
    input  wire logic        reg_rd_i,      // read strobe
    input  wire logic [15:0] vbat_mv_i,     // battery voltage in mV
    input  wire logic [8:0]  ichg_ma_i,     // charge current in mA
    output logic      [7:0]  reg_rdata_o,   // read data, registered
    output logic      [15:0] ov_thr_mv_o,   // ov threshold in mV
    output logic      [8:0]  oc_thr_ma_o,   // oc threshold in mA
    output logic      [15:0] soc0_mv_o,     // zero-percent voltage mV
    output logic             ov_fault_o,    // qualified overvoltage
    output logic             oc_fault_o     // qualified overcurrent
);
    // ==========================================================
    // register storage
    logic [4:0] ov_thr_q;
    logic [1:0] ov_hys_q;
    logic       ov_dgt_q;
    logic [2:0] oc_thr_q;
    logic [1:0] oc_dgt_q;
    logic [7:0] soc0_q;

    // overvoltage setting writes
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ov_thr_q <= OV_THR_RST;
            ov_hys_q <= `BPG_OV_HYS_RST;
            ov_dgt_q <= `BPG_OV_DGT_RST;
        end
        else if (reg_wr_i && reg_addr_i == `BPG_ADDR_OV)
        begin
            ov_thr_q <= reg_wdata_i[`BPG_OV_THR_HI:`BPG_OV_THR_LO];
            ov_hys_q <= reg_wdata_i[`BPG_OV_HYS_HI:`BPG_OV_HYS_LO];
            ov_dgt_q <= reg_wdata_i[`BPG_OV_DGT_BIT];
        end
    end

    // overcurrent setting writes, low bits reserved
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            oc_thr_q <= OC_THR_RST;
            oc_dgt_q <= `BPG_OC_DGT_RST;
        end
        else if (reg_wr_i && reg_addr_i == `BPG_ADDR_OC)
        begin
            oc_thr_q <= reg_wdata_i[`BPG_OC_THR_HI:`BPG_OC_THR_LO];
            oc_dgt_q <= reg_wdata_i[`BPG_OC_DGT_HI:`BPG_OC_DGT_LO];
        end
    end

    // breakpoint writes
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            soc0_q <= `BPG_SOC0_RST;
        else if (reg_wr_i && reg_addr_i == `BPG_ADDR_SOC0)
            soc0_q <= reg_wdata_i;
    end

    // ==========================================================
    // read back, unmapped reads zero
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                `BPG_ADDR_OV:   reg_rdata_o <= {ov_thr_q, ov_hys_q, ov_dgt_q};
                `BPG_ADDR_OC:   reg_rdata_o <= {oc_thr_q, oc_dgt_q, 3'h0};
                `BPG_ADDR_SOC0: reg_rdata_o <= soc0_q;
                default:        reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // threshold decoding
    logic [4:0]  ov_code;
    logic [15:0] ov_mv;
    logic [3:0]  hys_pct;
    logic [15:0] rel_mv;
    logic [8:0]  oc_ma;
    logic [15:0] soc0_mv;

    always_comb
    begin
        ov_code = (ov_thr_q > `BPG_OV_CODE_MAX) ? (`BPG_OV_CODE_MAX + 5'h01) : ov_thr_q;
        ov_mv   = `BPG_OV_MV_BASE + 16'(ov_code) * `BPG_OV_MV_STEP;
        // release percentage per hysteresis code
        unique case (ov_hys_q)
            2'h0:    hys_pct = `BPG_HYS_PCT_0;
            2'h1:    hys_pct = `BPG_HYS_PCT_1;
            2'h2:    hys_pct = `BPG_HYS_PCT_2;
            default: hys_pct = `BPG_HYS_PCT_3;
        endcase
        // release at threshold less 2/4/6/8 percent, truncated down
        rel_mv  = ov_mv - 16'((32'(ov_mv) * 32'(hys_pct)) / `BPG_PCT_DIV);
        unique case (oc_thr_q)
            3'h0:    oc_ma = 9'd25;
            3'h1:    oc_ma = 9'd50;
            3'h2:    oc_ma = 9'd100;
            3'h3:    oc_ma = 9'd150;
            3'h4:    oc_ma = 9'd200;
            3'h5:    oc_ma = 9'd250;
            3'h6:    oc_ma = 9'd300;
            default: oc_ma = 9'd400;
        endcase
        soc0_mv = `BPG_SOC0_MV_BASE + 16'(soc0_q) * `BPG_SOC0_MV_STEP;
    end

    // decoded values registered so every output leaves a flip-flop
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ov_thr_mv_o <= 16'h0000;
            oc_thr_ma_o <= 9'h000;
            soc0_mv_o   <= 16'h0000;
        end
        else
        begin
            ov_thr_mv_o <= ov_mv;
            oc_thr_ma_o <= oc_ma;
            soc0_mv_o   <= soc0_mv;
        end
    end

    // ==========================================================
    // 1 ms tick divider
    // one registered tick shared so both qualifiers count alike
    logic [`BPG_MS_W-1:0] div_q;
    logic                 ms_tick_q;

    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            div_q     <= '0;
            ms_tick_q <= 1'b0;
        end
        else
        begin
            ms_tick_q <= (div_q == `BPG_MS_W'(`BPG_MS_CYCLES - 1));
            div_q     <= (div_q == `BPG_MS_W'(`BPG_MS_CYCLES - 1)) ? '0 : div_q + 1'b1;
        end
    end

    // deglitch limits
    logic [`BPG_MS_CNT_W-1:0] ov_lim;
    logic [`BPG_MS_CNT_W-1:0] oc_lim;

    always_comb
    begin
        ov_lim = ov_dgt_q ? `BPG_MS_PER_S : `BPG_MS_PER_HALF_S;
        unique case (oc_dgt_q)
            2'h0:    oc_lim = `BPG_MS_5;
            2'h1:    oc_lim = `BPG_MS_10;
            2'h2:    oc_lim = `BPG_MS_20;
            default: oc_lim = `BPG_MS_40;
        endcase
    end

    // ==========================================================
    // fault qualifiers
    // comparator conditions feeding the qualifiers
    logic ov_trip;
    logic ov_clear;
    logic oc_trip;
    logic oc_clear;

    assign ov_trip  = vbat_mv_i >= ov_mv;
    assign ov_clear = vbat_mv_i < rel_mv;
    assign oc_trip  = ichg_ma_i >= oc_ma;
    assign oc_clear = !oc_trip;

    bpg_deglitch u_ov
    (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .ms_tick_i (ms_tick_q),
        .trip_i    (ov_trip),
        .clear_i   (ov_clear),
        .limit_i   (ov_lim),
        .fault_o   (ov_fault_o)
    );

    bpg_deglitch u_oc
    (
        .clock_i   (clock_i),
        .reset_i   (reset_i),
        .ms_tick_i (ms_tick_q),
        .trip_i    (oc_trip),
        .clear_i   (oc_clear),
        .limit_i   (oc_lim),
        .fault_o   (oc_fault_o)
    );
endmodule
`default_nettype wire

// file: verification/bpg_regs_monitor.sv
// port assertions for the configuration bank
`default_nettype none
`include "bpg_cfg.svh"
module bpg_regs_monitor (
    input wire logic        clock_i,     // system clock
    input wire logic        reset_i,     // async reset
    input wire logic [7:0]  reg_addr_i,  // address
    input wire logic        reg_wr_i,    // write strobe
    input wire logic [7:0]  reg_wdata_i, // write data
    input wire logic        reg_rd_i,    // read strobe
    input wire logic [15:0] vbat_mv_i,   // battery mV
    input wire logic [8:0]  ichg_ma_i,   // charge mA
    input wire logic [7:0]  reg_rdata_o, // read data
    input wire logic [15:0] ov_thr_mv_o, // ov threshold
    input wire logic [8:0]  oc_thr_ma_o, // oc threshold
    input wire logic [15:0] soc0_mv_o,   // zero-percent mV
    input wire logic        ov_fault_o,  // ov fault
    input wire logic        oc_fault_o   // oc fault
);
    // =========================================
    // write decode and ov readback shadow
    localparam logic [8:0] OC_MA [8] = '{9'h019, 9'h032, 9'h064, 9'h096, 9'h0C8, 9'h0FA, 9'h12C, 9'h190};
    logic       wr_ov;
    logic       wr_oc;
    logic       wr_soc;
    logic       shadow_ok_q;
    logic [7:0] ov_shadow_q;
    assign wr_ov  = reg_wr_i && reg_addr_i == `BPG_ADDR_OV;
    assign wr_oc  = reg_wr_i && reg_addr_i == `BPG_ADDR_OC;
    assign wr_soc = reg_wr_i && reg_addr_i == `BPG_ADDR_SOC0;
    // marks that the shadow holds a written value
    always_ff @(posedge clock_i or posedge reset_i)
    begin
        if (reset_i)
            shadow_ok_q <= 1'b0;
        else if (wr_ov)
            shadow_ok_q <= 1'b1;
    end
    // last value written to the ov register
    always_ff @(posedge clock_i)
    begin
        if (wr_ov)
            ov_shadow_q <= reg_wdata_i;
    end
    // =========================================
    // assertions
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (reset_i);
    property ov_step_p;
        logic [4:0] c;
        (wr_ov && reg_wdata_i[7:3] <= 5'h18, c = reg_wdata_i[7:3]) ##1 !wr_ov
            |-> ##1 ov_thr_mv_o == 16'hDDE + 16'(c) * 16'h32;
    endproperty
    property oc_map_p;
        logic [2:0] c;
        (wr_oc, c = reg_wdata_i[7:5]) ##1 !wr_oc |-> ##1 oc_thr_ma_o == OC_MA[c];
    endproperty
    property soc0_map_p;
        logic [7:0] v;
        (wr_soc, v = reg_wdata_i) ##1 !wr_soc |-> ##1 soc0_mv_o == 16'h9C4 + 16'(v) * 16'h8;
    endproperty
    property ov_back_p;
        logic [7:0] v;
        (reg_rd_i && !reg_wr_i && reg_addr_i == `BPG_ADDR_OV && shadow_ok_q, v = ov_shadow_q) |=> reg_rdata_o == v;
    endproperty
    ov_clamp_a: assert property ((wr_ov && reg_wdata_i[7:3] > 5'h18) ##1 !wr_ov |-> ##1 ov_thr_mv_o == 16'h12C0)
        else $error("ov threshold not clamped");
    ov_step_a: assert property (ov_step_p)
        else $error("ov threshold step wrong");
    ov_back_a: assert property (ov_back_p)
        else $error("ov register readback wrong");
    oc_map_a: assert property (oc_map_p)
        else $error("oc threshold wrong");
    oc_reserved_a: assert property (reg_rd_i && reg_addr_i == `BPG_ADDR_OC |=> reg_rdata_o[2:0] == 3'h0)
        else $error("oc reserved bits not zero");
    soc0_map_a: assert property (soc0_map_p)
        else $error("zero-percent voltage wrong");
    read_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without read");
    fault_floor_a: assert property ($rose(oc_fault_o) |-> $past(ichg_ma_i, 8) >= 9'h019)
        else $error("oc fault without current");
    cover property (wr_soc ##2 !reg_wr_i);
    cover property (wr_ov && reg_wdata_i[7:3] > 5'h18);
    cover property (reg_rd_i && reg_addr_i == `BPG_ADDR_OC);
endmodule
bind bpg_regs bpg_regs_monitor bpg_regs_monitor_i (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .vbat_mv_i(vbat_mv_i),
    .ichg_ma_i(ichg_ma_i), .reg_rdata_o(reg_rdata_o), .ov_thr_mv_o(ov_thr_mv_o), .oc_thr_ma_o(oc_thr_ma_o),
    .soc0_mv_o(soc0_mv_o), .ov_fault_o(ov_fault_o), .oc_fault_o(oc_fault_o));
`default_nettype wire

// file: verification/bpg_regs_tb_top.sv
// self-checking bench for the configuration bank
`default_nettype none
`include "bpg_cfg.svh"
module bpg_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================
    // stimulus signals and design instance
    localparam logic [8:0] OC_MA [8] = '{9'h019, 9'h032, 9'h064, 9'h096, 9'h0C8, 9'h0FA, 9'h12C, 9'h190};
    logic [7:0]  soc_v [3] = '{8'h00, 8'h80, 8'hFF};
    logic        clock_i     = 1'b0;
    logic        reset_i     = 1'b1;
    logic [7:0]  reg_addr_i  = 8'h00;
    logic        reg_wr_i    = 1'b0;
    logic [7:0]  reg_wdata_i = 8'h00;
    logic        reg_rd_i    = 1'b0;
    logic [15:0] vbat_mv_i   = 16'hBB8;
    logic [8:0]  ichg_ma_i   = 9'h000;
    logic [7:0]  reg_rdata_o;
    logic [15:0] ov_thr_mv_o;
    logic [8:0]  oc_thr_ma_o;
    logic [15:0] soc0_mv_o;
    logic        ov_fault_o;
    logic        oc_fault_o;
    integer      fails       = 0;
    integer      check_count = 0;
    integer      i;
    always #25 clock_i = ~clock_i;
    bpg_regs bpg_regs_i (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .vbat_mv_i(vbat_mv_i), .ichg_ma_i(ichg_ma_i),
        .reg_rdata_o(reg_rdata_o), .ov_thr_mv_o(ov_thr_mv_o), .oc_thr_ma_o(oc_thr_ma_o),
        .soc0_mv_o(soc0_mv_o), .ov_fault_o(ov_fault_o), .oc_fault_o(oc_fault_o));
    // =========================================
    // compare, bus and verdict tasks
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge clock_i);
        reg_wr_i    <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge clock_i);
        reg_rd_i   <= 1'b0;
        #1 check_val({8'h00, reg_rdata_o}, {8'h00, exp});
    endtask
    task automatic give_verdict;
        if (fails == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // =========================================
    // test sequence
    initial
    begin
        repeat (16) @(posedge clock_i);
        reset_i <= 1'b0;
        rd_reg(`BPG_ADDR_OV, 8'h68);
        rd_reg(`BPG_ADDR_OC, 8'h68);
        rd_reg(`BPG_ADDR_SOC0, 8'h7D);
        check_val(ov_thr_mv_o, 16'h1068);
        check_val({7'h00, oc_thr_ma_o}, 16'h0096);
        check_val(soc0_mv_o, 16'hDAC);
        // ov codes across the clamp boundary
        for (i = 'h13; i <= 'h1F; i++)
        begin
            wr_reg(`BPG_ADDR_OV, {i[4:0], i[1:0], i[0]});
            check_val(ov_thr_mv_o, (i > 'h18) ? 16'h12C0 : 16'hDDE + 16'(i) * 16'h32);
            rd_reg(`BPG_ADDR_OV, {i[4:0], i[1:0], i[0]});
        end
        // every oc code and deglitch code, reserved bits written high
        for (i = 0; i < 8; i++)
        begin
            wr_reg(`BPG_ADDR_OC, {i[2:0], i[1:0], 3'h7});
            check_val({7'h00, oc_thr_ma_o}, {7'h00, OC_MA[i]});
            rd_reg(`BPG_ADDR_OC, {i[2:0], i[1:0], 3'h0});
        end
        // zero-percent breakpoint at both ends and mid scale
        for (i = 0; i < 3; i++)
        begin
            wr_reg(`BPG_ADDR_SOC0, soc_v[i]);
            check_val(soc0_mv_o, 16'h9C4 + 16'(soc_v[i]) * 16'h8);
            rd_reg(`BPG_ADDR_SOC0, soc_v[i]);
        end
        // unmapped addresses leave the bank alone
        wr_reg(8'h17, 8'hAA);
        rd_reg(8'h17, 8'h00);
        rd_reg(`BPG_ADDR_SOC0, 8'hFF);
        // short overload is filtered by the deglitch timers
        @(posedge clock_i);
        vbat_mv_i <= 16'hFFFF;
        ichg_ma_i <= 9'h1FF;
        repeat (2000) @(posedge clock_i);
        #1 check_val({14'h0000, ov_fault_o, oc_fault_o}, 16'h0000);
        // back to nominal, then a second reset restores defaults
        @(posedge clock_i);
        vbat_mv_i <= 16'hBB8;
        ichg_ma_i <= 9'h000;
        reset_i   <= 1'b1;
        repeat (3) @(posedge clock_i);
        reset_i <= 1'b0;
        rd_reg(`BPG_ADDR_OV, 8'h68);
        rd_reg(`BPG_ADDR_SOC0, 8'h7D);
        rd_reg(`BPG_ADDR_OC, 8'h68);
        check_val(ov_thr_mv_o, 16'h1068);
        give_verdict();
    end
endmodule
`default_nettype wire
